// ===== logic/spi_port_regs.vh
// Purpose: register map, field positions and reset values of the serial port
// Assumes: AXI4-Lite word registers, data in the low byte
// Notes: Summary of operation below
// Summary of operation
// - receive-full or mode-fault raises interrupt when rx/fault enable is set
// - clearing port enable aborts transfer, flushes buffers, resets state machines
// - while disabled receive-full is clear and transmit-empty is set
// - transmit-empty raises interrupt while transmit enable is set
// - master select zero means slave, one means master driving the clock
// - clock polarity inverts serial clock; one idles high
// - phase zero puts first clock edge mid first bit
// - phase one puts first clock edge at start of first bit
// - low-bit-first zero shifts msb first, one shifts lsb first
// - master without fault detect releases select pin to general use
// - master with fault detect: select is fault input or automatic output
// - slave always uses select pin as active-low input
// - single-wire drive enable chooses shared pin input or output
// - drive enable ignored unless single-wire mode is selected
// - halt-in-wait stops port activity while processor waits
// - single-wire slave uses its master-in/slave-out pin for data
// - single-wire master uses its master-out/slave-in pin for data
// - unimplemented bits of second control register read zero
// - while disabled all four serial pins are undriven
// - master bit clock is bus clock over prescale 1-8 times divisor 2-256
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// register byte offsets
`define OFF_CTRL_ONE   8'h00
`define OFF_CTRL_TWO   8'h04
`define OFF_BAUD       8'h08
`define OFF_STATUS     8'h0c
`define OFF_DATA       8'h10

// control one fields
`define C1_RX_IE       7
`define C1_EN          6
`define C1_TX_IE       5
`define C1_MASTER_SELECT        4
`define C1_CLOCK_POLARITY        3
`define C1_CLOCK_PHASE        2
`define C1_SELECT_OUTPUT_ENABLE        1
`define C1_LSB         0

// control two fields
`define C2_FAULT_EN    4
`define C2_DRIVE_EN    3
`define C2_HALT_WAIT   1
`define C2_ONE_WIRE    0
`define C2_MASK        8'h1b

// baud fields
`define BR_PRE_HI      6
`define BR_PRE_LO      4
`define BR_RATE_HI     2
`define BR_RATE_LO     0
`define BR_MASK        8'h77

// status fields
`define ST_RX_FULL     7
`define ST_TX_EMPTY    5
`define ST_FAULT       4

// reset values
`define RST_CTRL_ONE   8'h00
`define RST_CTRL_TWO   8'h00
`define RST_BAUD       8'h00

// edges in one byte and responses
`define LAST_EDGE      4'hf
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ===== logic/spi_port.v
// Purpose: byte serial port, control and configuration with transfer engine
// Assumes: single aclk, serial pins sampled through two flip-flops
// Notes: pins are split into input, output and output enable
`timescale 1ns/1ns
`include "spi_port_regs.vh"

module spi_port #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              wait_mode,
  input  wire              sck_i,
  output reg               sck_o,
  output reg               sck_oe,
  input  wire              mosi_i,
  output reg               mosi_o,
  output reg               mosi_oe,
  input  wire              miso_i,
  output reg               miso_o,
  output reg               miso_oe,
  input  wire              ss_n_i,
  output reg               ss_n_o,
  output reg               ss_n_oe,
  output wire              irq
);

  // control registers
  reg  [7:0]        ctrl_one_q;
  reg  [7:0]        ctrl_two_q;
  reg  [7:0]        baud_q;
  // flags and buffers
  reg               rx_full_q;
  reg               tx_full_q;
  reg               fault_q;
  reg  [7:0]        rx_buf_q;
  reg  [7:0]        tx_buf_q;
  reg               rx_arm_q;
  reg               tx_arm_q;
  reg               fault_arm_q;
  // engine
  reg  [7:0]        sh_q;
  reg               in_q;
  reg  [3:0]        edge_q;
  reg               busy_q;
  reg  [10:0]       div_q;
  reg               sck_q;
  reg               tail_q;
  // pin synchronisers
  reg  [3:0]        pin_s1_q;
  reg  [3:0]        pin_s2_q;
  reg               sck_s3_q;
  // bus slave
  reg               aw_h_q;
  reg               w_h_q;
  reg  [ADDR_W-1:0] aw_addr_q;
  reg  [7:0]        w_data_q;
  reg               w_be_q;

  wire en       = ctrl_one_q[`C1_EN];
  wire master   = ctrl_one_q[`C1_MASTER_SELECT];
  wire clock_polarity     = ctrl_one_q[`C1_CLOCK_POLARITY];
  wire clock_phase     = ctrl_one_q[`C1_CLOCK_PHASE];
  wire select_output_enable     = ctrl_one_q[`C1_SELECT_OUTPUT_ENABLE];
  wire lsb      = ctrl_one_q[`C1_LSB];
  wire fault_en = ctrl_two_q[`C2_FAULT_EN];
  wire one_wire = ctrl_two_q[`C2_ONE_WIRE];
  wire drive_en = ctrl_two_q[`C2_DRIVE_EN] & one_wire;
  wire halt     = ctrl_two_q[`C2_HALT_WAIT] & wait_mode;
  wire run      = en & ~halt;

  // synchronised pins: 3 sck, 2 mosi, 1 miso, 0 select
  wire sck_s  = pin_s2_q[3];
  wire mosi_s = pin_s2_q[2];
  wire miso_s = pin_s2_q[1];
  wire ss_n_s = pin_s2_q[0];

  // two-flop synchronisers, third flop only for clock edge detect
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
      sck_s3_q <= 1'b1; // same level as second flop, no false edge
    end else begin
      pin_s1_q <= {sck_i, mosi_i, miso_i, ss_n_i};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= sck_s;
    end
  end

  // select pin roles
  wire ss_auto   = master & fault_en & select_output_enable;
  wire ss_fault  = master & fault_en & ~select_output_enable;
  wire slave_sel = ~master & ~ss_n_s;
  wire fault_ev  = en & ss_fault & ~ss_n_s;

  // half bit period in bus cycles: prescale times divisor over two
  wire [10:0] pre_plus = {8'h00, baud_q[`BR_PRE_HI:`BR_PRE_LO]} + 11'h001;
  wire [10:0] half     = pre_plus << baud_q[`BR_RATE_HI:`BR_RATE_LO];
  wire        tick     = busy_q & master & (div_q == 11'h000);

  // clock edges seen by the shifter
  wire slv_edge = ~master & slave_sel & (sck_s ^ sck_s3_q);
  wire ev       = run & (tick | slv_edge);
  wire samp_ev  = ev & (edge_q[0] == clock_phase);
  wire shft_ev  = ev & (edge_q[0] != clock_phase) & (edge_q != 4'h0);
  wire last_ev  = ev & (edge_q == `LAST_EDGE);

  // data input pin follows mode and single-wire routing
  reg din;
  always @* begin
    if (master)
      din = one_wire ? mosi_s : miso_s;
    else
      din = one_wire ? miso_s : mosi_s;
  end

  wire in_bit  = samp_ev ? din : in_q;
  wire dout    = lsb ? sh_q[0] : sh_q[7];
  wire [7:0] sh_nx = lsb ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};

  // load next byte into shifter
  wire load = run & ~busy_q & tx_full_q & (master | ~slave_sel | edge_q == 4'h0);

  // bus write and read decode
  wire aw_go = s_axi_awvalid & s_axi_awready;
  wire w_go  = s_axi_wvalid & s_axi_wready;
  wire ar_go = s_axi_arvalid & s_axi_arready;
  wire wr_do = (aw_h_q | aw_go) & (w_h_q | w_go) & ~s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_h_q ? aw_addr_q : s_axi_awaddr;
  wire [7:0]        wr_data = w_h_q ? w_data_q : s_axi_wdata[7:0];
  wire              wr_be   = w_h_q ? w_be_q : s_axi_wstrb[0];

  assign s_axi_awready = ~aw_h_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_h_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  reg wr_c1;
  reg wr_c2;
  reg wr_br;
  reg wr_dt;
  reg wr_ok;
  // write address decode
  always @* begin
    wr_c1 = 1'b0;
    wr_c2 = 1'b0;
    wr_br = 1'b0;
    wr_dt = 1'b0;
    wr_ok = 1'b1;
    if (wr_addr == `OFF_CTRL_ONE) begin
      wr_c1 = wr_do & wr_be;
    end else if (wr_addr == `OFF_CTRL_TWO) begin
      wr_c2 = wr_do & wr_be;
    end else if (wr_addr == `OFF_BAUD) begin
      wr_br = wr_do & wr_be;
    end else if (wr_addr == `OFF_DATA) begin
      wr_dt = wr_do & wr_be;
    end else if (wr_addr != `OFF_STATUS) begin
      wr_ok = 1'b0;
    end
  end

  reg [7:0] rd_val;
  reg       rd_ok;
  reg       rd_st;
  reg       rd_dt;
  // read address decode
  always @* begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    rd_st  = 1'b0;
    rd_dt  = 1'b0;
    if (s_axi_araddr == `OFF_CTRL_ONE) begin
      rd_val = ctrl_one_q;
    end else if (s_axi_araddr == `OFF_CTRL_TWO) begin
      rd_val = ctrl_two_q & `C2_MASK;
    end else if (s_axi_araddr == `OFF_BAUD) begin
      rd_val = baud_q;
    end else if (s_axi_araddr == `OFF_STATUS) begin
      rd_st = ar_go;
      rd_val[`ST_RX_FULL]  = rx_full_q;
      rd_val[`ST_TX_EMPTY] = ~tx_full_q;
      rd_val[`ST_FAULT]    = fault_q;
    end else if (s_axi_araddr == `OFF_DATA) begin
      rd_dt  = ar_go;
      rd_val = rx_buf_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // bus channel holding and responses
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_q       <= 1'b0;
      w_h_q        <= 1'b0;
      aw_addr_q    <= {ADDR_W{1'b0}};
      w_data_q     <= 8'h00;
      w_be_q       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_do) begin
        aw_h_q       <= 1'b0;
        w_h_q        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_go) begin
          aw_h_q    <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_go) begin
          w_h_q    <= 1'b1;
          w_data_q <= s_axi_wdata[7:0];
          w_be_q   <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_q <= `RST_CTRL_ONE;
      ctrl_two_q <= `RST_CTRL_TWO;
      baud_q     <= `RST_BAUD;
    end else begin
      if (wr_c1)
        ctrl_one_q <= wr_data;
      if (wr_c2)
        ctrl_two_q <= wr_data & `C2_MASK;
      if (wr_br)
        baud_q <= wr_data & `BR_MASK;
    end
  end

  // flags, buffers and clear sequences; a hardware set beats a clear
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      rx_full_q   <= 1'b0;
      tx_full_q   <= 1'b0;
      rx_buf_q    <= 8'h00;
      tx_buf_q    <= 8'h00;
      rx_arm_q    <= 1'b0;
      tx_arm_q    <= 1'b0;
      fault_arm_q <= 1'b0;
      if (!aresetn)
        fault_q <= 1'b0;
      else if (wr_c1 && fault_arm_q)
        fault_q <= 1'b0;
    end else begin
      if (rd_st) begin
        rx_arm_q    <= rx_full_q;
        tx_arm_q    <= ~tx_full_q;
        fault_arm_q <= fault_q;
      end
      // receive completes a byte
      if (last_ev) begin
        rx_full_q <= 1'b1;
        rx_buf_q  <= sh_nx; // last bit joins on the final edge
      end else if (rd_dt && rx_arm_q) begin
        rx_full_q <= 1'b0;
        rx_arm_q  <= 1'b0;
      end
      // transmit buffer write after status read
      if (wr_dt && tx_arm_q && !tx_full_q) begin
        tx_buf_q  <= wr_data;
        tx_full_q <= 1'b1;
        tx_arm_q  <= 1'b0;
      end else if (load) begin
        tx_full_q <= 1'b0;
      end
      if (fault_ev) begin
        fault_q <= 1'b1;
      end else if (wr_c1 && fault_arm_q) begin
        fault_q     <= 1'b0;
        fault_arm_q <= 1'b0;
      end
    end
  end

  // transfer engine, held in its initial state while disabled
  always @(posedge aclk) begin
    if (!aresetn || !en || fault_ev) begin
      sh_q   <= 8'h00;
      in_q   <= 1'b0;
      edge_q <= 4'h0;
      busy_q <= 1'b0;
      div_q  <= 11'h000;
      sck_q  <= 1'b0;
    end else if (run) begin
      if (!busy_q)
        sck_q <= clock_polarity;
      if (!master && !slave_sel && !busy_q)
        edge_q <= 4'h0;
      if (load) begin
        sh_q   <= tx_buf_q;
        busy_q <= master;
        div_q  <= half - 11'h001;
      end else begin
        if (tick) begin
          div_q <= half - 11'h001;
          sck_q <= ~sck_q;
        end else if (busy_q && master) begin
          div_q <= div_q - 11'h001;
        end
        if (samp_ev)
          in_q <= din;
        if (shft_ev) // with phase one, data line holds after the last sample edge
          sh_q <= sh_nx;
        if (ev)
          edge_q <= edge_q + 4'h1;
        if (last_ev)
          busy_q <= 1'b0;
      end
    end
  end

  // pin drivers and enables
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      sck_o   <= 1'b0;
      sck_oe  <= 1'b0;
      mosi_o  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_o  <= 1'b1;
      ss_n_oe <= 1'b0;
      tail_q  <= 1'b0;
    end else begin
      tail_q  <= busy_q; // select outlasts the last clock edge
      sck_o   <= busy_q ? sck_q : clock_polarity;
      sck_oe  <= master;
      mosi_o  <= dout;
      miso_o  <= dout;
      mosi_oe <= master & (~one_wire | drive_en);
      miso_oe <= ~master & slave_sel & (~one_wire | drive_en);
      ss_n_o  <= ~(busy_q | load | tail_q);
      ss_n_oe <= ss_auto;
    end
  end

  // interrupt request from flags and enables
  assign irq = (ctrl_one_q[`C1_RX_IE] & (rx_full_q | fault_q))
             | (ctrl_one_q[`C1_TX_IE] & ~tx_full_q);

endmodule // spi_port

// ===== tb/spi_port_checker.sv
// Purpose: port checks of pin ownership, select timing and register reads
// Assumes: write address and data offered together with all strobes
// Notes: control registers shadowed from the bus; checks wait 3 cycles
`timescale 1ns/1ns
module spi_port_checker #(
  parameter ADDR_W = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire              sck_o,
  input wire              sck_oe,
  input wire              mosi_oe,
  input wire              miso_oe,
  input wire              ss_n_o,
  input wire              ss_n_oe,
  input wire              wait_mode,
  input wire              irq
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [1:0] age_q;
  wire        aw_go = s_axi_awvalid & s_axi_awready;
  wire        ok    = age_q == 2'h3;
  wire        en    = c1_q[6];
  wire        ms    = c1_q[4];
  wire        ow    = c2_q[0];
  wire        de    = c2_q[3];
  wire        aut   = ok & en & ms & c2_q[4] & c1_q[1];
  // shadow of both control registers and age since last control write
  always @(posedge aclk) begin
    if (!aresetn || (aw_go && s_axi_awaddr < ADDR_W'(8))) begin
      age_q <= 2'h0;
    end else if (!ok) begin
      age_q <= age_q + 2'h1;
    end
    if (!aresetn) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (aw_go && s_axi_awaddr == ADDR_W'(0)) begin
      c1_q <= s_axi_wdata[7:0];
    end else if (aw_go && s_axi_awaddr == ADDR_W'(4)) begin
      c2_q <= s_axi_wdata[7:0] & 8'h1b;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // select falls at byte start, then stays low for eight cycles
  sequence s_sel; aut && ss_n_oe && $fell(ss_n_o); endsequence
  sequence s_low; !ss_n_o [*8]; endsequence
  property p_off; ok && !en |-> !sck_oe && !mosi_oe && !miso_oe && !ss_n_oe; endproperty
  property p_ssin; ok && en && ms && !(c2_q[4] && c1_q[1]) |-> !ss_n_oe; endproperty
  property p_slv; ok && en && !ms |-> !ss_n_oe && !sck_oe; endproperty
  property p_mow; ok && en && ms && ow |-> !miso_oe && mosi_oe == de; endproperty
  property p_sow; ok && en && !ms && ow |-> !mosi_oe && (de || !miso_oe); endproperty
  property p_sep; ok && en && ms && !ow |-> !miso_oe && mosi_oe; endproperty
  property p_halt; aut && c2_q[1] && wait_mode && !aw_go |-> ##2 $stable(sck_o); endproperty
  property p_idle; aut && ss_n_o && sck_oe |-> sck_o == c1_q[3]; endproperty
  property p_hold; s_sel |=> s_low; endproperty
  property p_c2rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(4)
      |=> (s_axi_rdata & 32'hffffffe4) == 32'h0;
  endproperty
  property p_irq; ok && !en && !c1_q[7] |-> irq == c1_q[5]; endproperty
  a_off: assert property (p_off) else $error("pin driven while disabled");
  a_ssin: assert property (p_ssin) else $error("select driven");
  a_slv: assert property (p_slv) else $error("slave drives clock or select");
  a_mow: assert property (p_mow) else $error("master wire drive");
  a_sow: assert property (p_sow) else $error("slave wire drive");
  a_sep: assert property (p_sep) else $error("master drives data in");
  a_idle: assert property (p_idle) else $error("clock idle level");
  a_hold: assert property (p_hold) else $error("select left early");
  a_c2rd: assert property (p_c2rd) else $error("empty bits set");
  a_irq: assert property (p_irq) else $error("request while disabled");
  a_halt: assert property (p_halt) else $error("clock moved in wait");
endmodule // spi_port_checker

bind spi_port spi_port_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq(irq),
  .wait_mode(wait_mode)
);

// ===== tb/spi_slave_model.sv
// Purpose: behavioural serial slave facing the port in master mode
// Assumes: format bits given by the bench
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ns
module spi_slave_model (
  input  wire        sck,
  input  wire        ss_n,
  input  wire        mosi,
  input  wire        clock_polarity,
  input  wire        clock_phase,
  input  wire        lsb_first,
  input  wire [7:0]  tx_byte,
  output logic       miso,
  output logic [7:0] rx_byte
);
  int oi = 0;
  int ii = 0;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  // select starts a byte, release inverts the line
  always @(ss_n) begin
    if (!ss_n) begin
      oi = clock_phase ? 0 : 1;
      ii = 0;
      if (!clock_phase) miso = lsb_first ? tx_byte[0] : tx_byte[7];
    end else begin
      miso = ~miso;
    end
  end
  // leading edge leaves idle level; phase picks sample or shift
  always @(sck) begin
    if (!ss_n) begin
      if ((sck != clock_polarity) ^ clock_phase) begin
        if (ii < 8) rx_byte[lsb_first ? ii : 7 - ii] = mosi;
        ii = ii + 1;
      end else if (oi < 8) begin
        miso = tx_byte[lsb_first ? oi : 7 - oi];
        oi = oi + 1;
      end
    end
  end
endmodule // spi_slave_model

// ===== tb/spi_control_config_bench.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: pull-up on select, slave model on the data lines
// Notes: every format in turn, random rates and settings from a fixed seed
`timescale 1ns/1ns
module spi_control_config_bench;
  logic        aclk, aresetn, wait_mode;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, irq;
  wire         slv_miso;
  wire  [7:0]  slv_rx;
  // wire levels seen by both ends
  wire         sck_i  = sck_oe ? sck_o : ~sck_o;
  wire         mosi_i = mosi_oe ? mosi_o : ~mosi_o;
  wire         miso_i = miso_oe ? miso_o : slv_miso;
  wire         ss_n_i = ss_n_oe ? ss_n_o : 1'b1;
  int          seed = 64;
  int          wseed = 64;
  int          err_total = 0;
  int          checks = 0;
  logic [31:0] q;
  logic [1:0]  r;
  logic [7:0]  v, txb, slv_tx;
  logic [2:0]  fmt;

  spi_port u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_mode, .sck_i, .sck_o, .sck_oe,
    .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .ss_n_o,
    .ss_n_oe, .irq
  );
  spi_slave_model u_slave (
    .sck(sck_i), .ss_n(ss_n_i), .mosi(mosi_i), .clock_polarity(fmt[2]), .clock_phase(fmt[1]),
    .lsb_first(fmt[0]), .tx_byte(slv_tx), .miso(slv_miso), .rx_byte(slv_rx)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) wait_mode <= $random(wseed);

  task close_out;
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one bus transfer; ready and answers looked at mid-cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic pa, pd, ka, kd;
    @(posedge aclk);
    pa = 1'b1;
    pd = w;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    while (pa || pd) begin
      @(negedge aclk);
      ka = pa && (w ? s_axi_awready : s_axi_arready);
      kd = pd && s_axi_wready;
      @(posedge aclk);
      if (ka) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (kd) s_axi_wvalid <= 1'b0;
      pa = pa && !ka;
      pd = pd && !kd;
    end
    do @(negedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    chk(r, 0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  initial begin
    {aresetn, fmt, slv_tx, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, empty bits
    for (int i = 0; i < 3; i++) rd(8'(i * 4), 32'h0);
    rd(8'h0c, 32'h20);
    bus(1'b0, 8'h14, 8'h00);
    chk(r, 2'b10);
    wr(8'h04, 8'hff);
    rd(8'h04, 32'h1b);
    // random settings while disabled
    repeat (4) begin
      v = $random(seed) & 32'hbf;
      wr(8'h00, v);
      rd(8'h00, {24'h0, v});
      chk(irq, v[5]);
    end
    // pin ownership over master, slave and single-wire settings
    for (int i = 0; i < 6; i++) begin
      wr(8'h04, i % 3 == 0 ? 8'h01 : i % 3 == 1 ? 8'h09 : 8'h11);
      wr(8'h00, i < 3 ? 8'h50 : 8'h40);
      repeat (4) @(posedge aclk);
    end
    // byte transfers over every format, last one aborted
    for (int m = 0; m < 9; m++) begin
      fmt = m[2:0];
      v = $random(seed);
      wr(8'h08, {4'h0 | v[1:0], 3'h1, v[2]} << 0);
      wr(8'h04, {3'h0, 1'b1, m[1], 1'b0, m[0], 1'b0});
      wr(8'h00, {4'hd, fmt[2:1], 1'b1, fmt[0]});
      txb = $random(seed);
      slv_tx = $random(seed);
      rd(8'h0c, 32'h20);
      wr(8'h10, txb);
      if (m == 8) begin
        repeat (20) @(posedge aclk);
        wr(8'h00, {5'h0, fmt[1], 2'h0});
        rd(8'h0c, 32'h20);
        rd(8'h10, 32'h0);
      end else begin
        do bus(1'b0, 8'h0c, 8'h00); while (!q[7]);
        chk(irq, 1);
        rd(8'h10, {24'h0, slv_tx});
        chk(slv_rx, txb);
        chk(irq, 0);
        wr(8'h00, {5'h0, fmt[1], 2'h0});
      end
    end
    close_out;
  end
endmodule // spi_control_config_bench
